/* File: logic/tmr_pkg.sv */
// shared constants and types of the thermal monitor register bank
package tmr_pkg;
    // read addresses
    localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] RD_REMOTE_UPPER = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
    localparam logic [7:0] RD_REMOTE_HIGH_UP = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOW_UP = 8'h08;
    localparam logic [7:0] RD_REMOTE_LOWER = 8'h10;
    localparam logic [7:0] RD_PART_ID = 8'h3D;
    localparam logic [7:0] RD_MAKER_ID = 8'hFE;
    localparam logic [7:0] RD_REVISION = 8'hFF;
    // write addresses
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_RATE = 8'h0A;
    localparam logic [7:0] WR_LOCAL_HIGH = 8'h0B;
    localparam logic [7:0] WR_LOCAL_LOW = 8'h0C;
    localparam logic [7:0] WR_REMOTE_HIGH_UP = 8'h0D;
    localparam logic [7:0] WR_REMOTE_LOW_UP = 8'h0E;
    localparam logic [7:0] WR_ONE_SHOT = 8'h0F;
    // shared read/write addresses
    localparam logic [7:0] RW_OFFSET_UPPER = 8'h11;
    localparam logic [7:0] RW_OFFSET_LOWER = 8'h12;
    localparam logic [7:0] RW_REMOTE_HIGH_LO = 8'h13;
    localparam logic [7:0] RW_REMOTE_LOW_LO = 8'h14;
    localparam logic [7:0] RW_REMOTE_CRIT = 8'h19;
    localparam logic [7:0] RW_LOCAL_CRIT = 8'h20;
    localparam logic [7:0] RW_CRIT_HYST = 8'h21;
    localparam logic [7:0] RW_ALERT_FILTER = 8'h22;
    // reset values
    localparam logic [7:0] RST_CONFIG = 8'h08;
    localparam logic [7:0] RST_RATE = 8'h06;
    localparam logic [7:0] RST_HIGH = 8'h55;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CRIT = 8'h55;
    localparam logic [7:0] RST_HYST = 8'h0A;
    localparam logic [7:0] RST_FILTER = 8'h01;
    // field positions
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CFG_PIN6_MODE_BIT = 5;
    localparam int FLT_TO_HI_BIT = 7;
    localparam int FLT_TO_LO_BIT = 6;
    localparam logic [7:0] RATE_MASK = 8'h0F;
    localparam logic [7:0] FRAC_MASK = 8'hC0;
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int BUS_TIMEOUT_MS = 25;
    localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic open_circuit;
        logic [9:0] remote;
        logic [7:0] loc;
    } tmr_meas_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ACK = 3'b010,
        BUS_WDATA = 3'b011,
        BUS_RDATA = 3'b100,
        BUS_WAIT = 3'b101
    } tmr_bus_state_t;
endpackage

/* File: logic/tmr_regs.sv */
// serial-bus slave, register bank and limit logic of the thermal monitor
// How it works
// [RL1] remote offset is ten-bit two's complement: high byte, then left-justified low bits
// [RL2] only top two bits of offset low byte are kept, quarter-degree steps
// [RL3] offset high-byte msb is the sign, range -128 to +127.75
// [RL4] signed offset is added to each remote result before storing and comparing
// [RL5] both offset registers reset to zero, leaving results uncorrected
// [RL6] write to one-shot address in standby runs one conversion on both channels
// [RL7] one-shot data byte is discarded, nothing stored
// [RL8] filter bits 3..1 set consecutive violation count 1 to 4
// [RL9] filter register resets to need one violation
// [RL10] enabled bus timeout drops the transfer after 25 ms idle; off at reset
// [RL11] host sets filter bits 7 and 6 together to enable the timeout
// [RL12] local high limit: separate read and write address, resets to 85
// [RL13] local low limit: separate read and write address, resets to zero
// [RL14] remote high limit upper byte split addresses, resets 85; low byte shared
// [RL15] remote low limit upper byte split addresses, resets zero; low byte shared
// [RL16] measurement bytes are read-only, no write address, reset to zero
// [RL17] device is only a slave on the management bus
// [RL18] any high, low or open flag sets the alert latch, driving alert low
// [RL19] first write byte loads the pointer, optional second writes selected register
// [RL20] writes carry one or two bytes, reads return one byte
// [RL21] violation counter clears on any in-limit conversion
module tmr_regs #(
    parameter logic [6:0] SLAVE_ADDR = 7'h4C,
    parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
    parameter logic [7:0] REVISION = 8'h01, // arbitrary value
    parameter int TIMEOUT_CYC = tmr_pkg::BUS_TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic alert_out_n,
    output logic critical_overtemp_out_n,
    output logic second_critical_out_n,
    input wire logic meas_clk,
    input wire logic meas_valid,
    input wire tmr_pkg::tmr_meas_t meas_data,
    output logic meas_run
);
    // pin synchronisers
    logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
    always_ff @(posedge clk) begin
        scl_s1 <= scl_in;
        scl_s2 <= scl_s1;
        scl_p <= scl_s2;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        sda_p <= sda_s2;
    end
    wire bus_start = scl_s2 & scl_p & sda_p & ~sda_s2;
    wire bus_stop = scl_s2 & scl_p & ~sda_p & sda_s2;
    wire scl_rise = scl_s2 & ~scl_p;
    wire scl_fall = ~scl_s2 & scl_p;
    wire bus_act = (scl_s2 ^ scl_p) | (sda_s2 ^ sda_p);

    // registers
    logic [7:0] ptr, cfg, rate, lhigh, llow, rhigh_u, rlow_u, rhigh_l, rlow_l;
    logic [7:0] off_u, off_l, rcrit, lcrit, hyst, filt, ltemp, rtemp_u, rtemp_l;
    logic [6:2] flags;
    logic oneshot_pend, crit_l, crit_r, crit2_l, crit2_r, alert_latch;

    // slave engine
    tmr_pkg::tmr_bus_state_t st;
    logic [7:0] shreg;
    logic [2:0] bitc;
    logic [1:0] nbytes;
    logic is_read, ack_on, drive;
    logic [20:0] idle_cnt;

    wire to_en = filt[tmr_pkg::FLT_TO_HI_BIT] & filt[tmr_pkg::FLT_TO_LO_BIT]; // [RL10] [RL11]
    wire timed_out = to_en & (st != tmr_pkg::BUS_IDLE)
        & (idle_cnt >= 21'(TIMEOUT_CYC)); // [RL10]
    wire [7:0] shifted = {shreg[6:0], sda_s2};
    wire last_bit = scl_rise & (bitc == 3'h7);
    wire addr_hit = shifted[7:1] == SLAVE_ADDR;
    wire wr_byte = (st == tmr_pkg::BUS_WDATA) & last_bit;
    wire wr_ptr = wr_byte & (nbytes == 2'd0); // [RL19]
    wire wr_reg = wr_byte & (nbytes == 2'd1); // [RL19] [RL20]
    wire ack_start = (st == tmr_pkg::BUS_ACK) & scl_fall & ~ack_on;
    wire ack_end = (st == tmr_pkg::BUS_ACK) & scl_fall & ack_on;
    wire rd_load = ack_end & is_read;
    wire status_rd = rd_load & (ptr == tmr_pkg::RD_STATUS);

    // read mux
    logic [7:0] rdata;
    always_comb begin
        unique case (ptr)
            tmr_pkg::RD_LOCAL_TEMP: rdata = ltemp;
            tmr_pkg::RD_REMOTE_UPPER: rdata = rtemp_u;
            tmr_pkg::RD_STATUS: rdata = {oneshot_pend, flags, crit_r, crit_l};
            tmr_pkg::RD_CONFIG: rdata = cfg;
            tmr_pkg::RD_RATE: rdata = rate;
            tmr_pkg::RD_LOCAL_HIGH: rdata = lhigh; // [RL12]
            tmr_pkg::RD_LOCAL_LOW: rdata = llow; // [RL13]
            tmr_pkg::RD_REMOTE_HIGH_UP: rdata = rhigh_u; // [RL14]
            tmr_pkg::RD_REMOTE_LOW_UP: rdata = rlow_u; // [RL15]
            tmr_pkg::RD_REMOTE_LOWER: rdata = rtemp_l; // [RL16]
            tmr_pkg::RW_OFFSET_UPPER: rdata = off_u;
            tmr_pkg::RW_OFFSET_LOWER: rdata = off_l;
            tmr_pkg::RW_REMOTE_HIGH_LO: rdata = rhigh_l;
            tmr_pkg::RW_REMOTE_LOW_LO: rdata = rlow_l;
            tmr_pkg::RW_REMOTE_CRIT: rdata = rcrit;
            tmr_pkg::RW_LOCAL_CRIT: rdata = lcrit;
            tmr_pkg::RW_CRIT_HYST: rdata = hyst;
            tmr_pkg::RW_ALERT_FILTER: rdata = filt;
            tmr_pkg::RD_PART_ID: rdata = PART_ID;
            tmr_pkg::RD_MAKER_ID: rdata = MAKER_ID;
            tmr_pkg::RD_REVISION: rdata = REVISION;
            default: rdata = 8'h00;
        endcase
    end

    // slave only: the engine never drives scl and never starts a transfer
    always_ff @(posedge clk) begin // [RL17]
        if (srst | bus_stop | timed_out) begin // [RL10]
            st <= tmr_pkg::BUS_IDLE;
            drive <= 1'b0;
            bitc <= 3'h0;
            nbytes <= 2'd0;
            is_read <= 1'b0;
            ack_on <= 1'b0;
            shreg <= 8'h00;
        end else if (bus_start) begin
            st <= tmr_pkg::BUS_ADDR;
            drive <= 1'b0;
            bitc <= 3'h0;
            nbytes <= 2'd0;
            ack_on <= 1'b0;
        end else begin
            unique case (st)
                tmr_pkg::BUS_IDLE: drive <= 1'b0;
                tmr_pkg::BUS_ADDR: if (scl_rise) begin
                    shreg <= shifted;
                    bitc <= bitc + 3'h1;
                    if (last_bit) begin
                        st <= addr_hit ? tmr_pkg::BUS_ACK : tmr_pkg::BUS_WAIT;
                        is_read <= shifted[0];
                    end
                end
                tmr_pkg::BUS_ACK: if (ack_start) begin
                    drive <= 1'b1;
                    ack_on <= 1'b1;
                end else if (ack_end) begin
                    ack_on <= 1'b0;
                    bitc <= 3'h0;
                    shreg <= rdata;
                    drive <= is_read & ~rdata[7];
                    st <= is_read ? tmr_pkg::BUS_RDATA : tmr_pkg::BUS_WDATA;
                end
                tmr_pkg::BUS_WDATA: if (scl_rise) begin
                    shreg <= shifted;
                    bitc <= bitc + 3'h1;
                    if (last_bit) begin
                        nbytes <= nbytes + 2'd1;
                        // a third byte is refused with a no-acknowledge
                        st <= nbytes[1] ? tmr_pkg::BUS_WAIT : tmr_pkg::BUS_ACK; // [RL20]
                    end
                end
                tmr_pkg::BUS_RDATA: if (scl_rise) begin
                    bitc <= bitc + 3'h1;
                    if (last_bit) begin
                        st <= tmr_pkg::BUS_WAIT; // [RL20]
                    end
                end else if (scl_fall) begin
                    shreg <= {shreg[6:0], 1'b0};
                    drive <= ~shreg[6];
                end
                tmr_pkg::BUS_WAIT: if (scl_fall) begin
                    drive <= 1'b0;
                end
                default: st <= tmr_pkg::BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst | bus_act | (st == tmr_pkg::BUS_IDLE)) begin
            idle_cnt <= 21'h0;
        end else if (~timed_out) begin
            idle_cnt <= idle_cnt + 21'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ptr <= 8'h00;
        end else if (wr_ptr) begin
            ptr <= shifted; // [RL19]
        end
    end

    // register writes, decoded by write address
    wire [7:0] wd = shifted;
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg <= tmr_pkg::RST_CONFIG;
            rate <= tmr_pkg::RST_RATE;
            lhigh <= tmr_pkg::RST_HIGH; // [RL12]
            llow <= tmr_pkg::RST_ZERO; // [RL13]
            rhigh_u <= tmr_pkg::RST_HIGH; // [RL14]
            rlow_u <= tmr_pkg::RST_ZERO; // [RL15]
            rhigh_l <= tmr_pkg::RST_ZERO;
            rlow_l <= tmr_pkg::RST_ZERO;
            off_u <= tmr_pkg::RST_ZERO; // [RL5]
            off_l <= tmr_pkg::RST_ZERO; // [RL5]
            rcrit <= tmr_pkg::RST_CRIT;
            lcrit <= tmr_pkg::RST_CRIT;
            hyst <= tmr_pkg::RST_HYST;
            filt <= tmr_pkg::RST_FILTER; // [RL9] [RL10]
        end else if (wr_reg) begin
            unique case (ptr)
                tmr_pkg::WR_CONFIG: cfg <= wd;
                tmr_pkg::WR_RATE: rate <= wd & tmr_pkg::RATE_MASK;
                tmr_pkg::WR_LOCAL_HIGH: lhigh <= wd; // [RL12]
                tmr_pkg::WR_LOCAL_LOW: llow <= wd; // [RL13]
                tmr_pkg::WR_REMOTE_HIGH_UP: rhigh_u <= wd; // [RL14]
                tmr_pkg::WR_REMOTE_LOW_UP: rlow_u <= wd; // [RL15]
                tmr_pkg::RW_REMOTE_HIGH_LO: rhigh_l <= wd & tmr_pkg::FRAC_MASK; // [RL14]
                tmr_pkg::RW_REMOTE_LOW_LO: rlow_l <= wd & tmr_pkg::FRAC_MASK; // [RL15]
                tmr_pkg::RW_OFFSET_UPPER: off_u <= wd; // [RL1] [RL3]
                tmr_pkg::RW_OFFSET_LOWER: off_l <= wd & tmr_pkg::FRAC_MASK; // [RL1] [RL2]
                tmr_pkg::RW_REMOTE_CRIT: rcrit <= wd;
                tmr_pkg::RW_LOCAL_CRIT: lcrit <= wd;
                tmr_pkg::RW_CRIT_HYST: hyst <= wd;
                tmr_pkg::RW_ALERT_FILTER: filt <= wd; // [RL8] [RL11]
                // one-shot data and measurement addresses store nothing
                default: ;
            endcase
        end
    end

    // one-shot request; data byte ignored
    wire oneshot_wr = wr_reg & (ptr == tmr_pkg::WR_ONE_SHOT); // [RL6] [RL7]
    wire standby = cfg[tmr_pkg::CFG_STANDBY_BIT];
    logic run_req, res_take;
    always_ff @(posedge clk) begin
        if (srst) begin
            oneshot_pend <= 1'b0;
        end else if (oneshot_wr & standby) begin
            oneshot_pend <= 1'b1; // [RL6]
        end else if (res_take) begin
            oneshot_pend <= 1'b0; // [RL6]
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            run_req <= 1'b0;
        end else begin
            run_req <= ~standby | oneshot_pend | (oneshot_wr & standby);
        end
    end

    // measurement domain: result handed over by toggle handshake
    logic ctgl_s1, ctgl_s2, ctgl_ack;
    logic mrst_s1, mrst_s2, run_s1, run_s2, ack_s1, ack_s2, mtgl;
    tmr_pkg::tmr_meas_t hold;
    always_ff @(posedge meas_clk) begin
        mrst_s1 <= srst;
        mrst_s2 <= mrst_s1;
        run_s1 <= run_req;
        run_s2 <= run_s1;
        ack_s1 <= ctgl_ack;
        ack_s2 <= ack_s1;
    end
    // new results are dropped while the previous one is still in flight
    wire m_free = (mtgl == ack_s2);
    always_ff @(posedge meas_clk) begin
        if (mrst_s2) begin
            mtgl <= 1'b0;
            hold <= '0;
            meas_run <= 1'b0;
        end else begin
            meas_run <= run_s2;
            if (meas_valid & m_free) begin
                hold <= meas_data;
                mtgl <= ~mtgl;
            end
        end
    end

    // only ctgl_s2 is read past the pair, so the first flop never reaches logic
    always_ff @(posedge clk) begin
        ctgl_s1 <= mtgl;
        ctgl_s2 <= ctgl_s1;
        ctgl_ack <= srst ? 1'b0 : ctgl_s2;
    end
    wire res_new = ctgl_s2 ^ ctgl_ack;
    assign res_take = res_new & (~standby | oneshot_pend);

    // offset correction, clamped to the result range
    wire [9:0] offset = {off_u, off_l[7:6]}; // [RL1] [RL2] [RL3]
    wire [11:0] rsum = {2'b00, hold.remote} + {{2{offset[9]}}, offset}; // [RL4]
    wire [9:0] rcorr = rsum[11] ? 10'h000 : (rsum[10] ? 10'h3FF : rsum[9:0]); // [RL4]

    // limit comparisons; the remote ones use the corrected value, the local ones the raw reading
    wire [9:0] rhigh10 = {rhigh_u, rhigh_l[7:6]};
    wire [9:0] rlow10 = {rlow_u, rlow_l[7:6]};
    wire v_lh = hold.loc > lhigh;
    wire v_ll = hold.loc <= llow;
    wire v_rh = rcorr > rhigh10; // [RL4]
    wire v_rl = rcorr <= rlow10; // [RL4]
    wire v_op = hold.open_circuit;
    wire [6:2] viol = {v_lh, v_ll, v_rh, v_rl, v_op};

    // consecutive violation filter
    wire [2:0] need = 3'd1 + {2'b00, filt[1]} + {2'b00, filt[2]} + {2'b00, filt[3]}; // [RL8]
    logic [2:0] vcnt;
    logic [6:2] cur_viol;
    wire [2:0] vcnt_inc = (vcnt == 3'd4) ? 3'd4 : vcnt + 3'd1;
    wire trip = res_take & (|viol) & (vcnt_inc >= need); // [RL8]

    // sticky flags; a new trip wins over a clearing status read
    wire [6:2] clr = status_rd ? ~cur_viol : 5'h00;
    always_ff @(posedge clk) begin
        if (srst) begin
            flags <= 5'h00;
            alert_latch <= 1'b0;
        end else begin
            flags <= (flags & ~clr) | (trip ? viol : 5'h00);
            // latch released once flags are all clear
            alert_latch <= |flags; // [RL18]
        end
    end

    // critical limits with hysteresis
    wire [7:0] rt_u = rcorr[9:2];
    wire [8:0] lcrit_rel = {1'b0, lcrit} - {1'b0, hyst};
    wire [8:0] rcrit_rel = {1'b0, rcrit} - {1'b0, hyst};
    wire [8:0] lhigh_rel = {1'b0, lhigh} - {1'b0, hyst};
    wire [8:0] rhigh_rel = {1'b0, rhigh_u} - {1'b0, hyst};
    always_ff @(posedge clk) begin
        if (srst) begin
            crit_l <= 1'b0;
            crit_r <= 1'b0;
            crit2_l <= 1'b0;
            crit2_r <= 1'b0;
            vcnt <= 3'd0;
            cur_viol <= 5'h00;
            ltemp <= 8'h00; // [RL16]
            rtemp_u <= 8'h00; // [RL16]
            rtemp_l <= 8'h00; // [RL16]
        end else if (res_take) begin
            vcnt <= (|viol) ? vcnt_inc : 3'd0; // [RL21]
            cur_viol <= viol;
            ltemp <= hold.loc;
            rtemp_u <= rcorr[9:2]; // [RL4]
            rtemp_l <= {rcorr[1:0], 6'h00};
            crit_l <= (hold.loc > lcrit) | (crit_l & ({1'b0, hold.loc} > lcrit_rel));
            crit_r <= (rt_u > rcrit) | (crit_r & ({1'b0, rt_u} > rcrit_rel));
            crit2_l <= v_lh | (crit2_l & ({1'b0, hold.loc} > lhigh_rel));
            crit2_r <= v_rh | (crit2_r & ({1'b0, rt_u} > rhigh_rel));
        end
    end

    // pins
    wire pin6_crit2 = cfg[tmr_pkg::CFG_PIN6_MODE_BIT];
    wire alert_drv = alert_latch & ~cfg[tmr_pkg::CFG_MASK_BIT] & ~pin6_crit2; // [RL18]
    always_ff @(posedge clk) begin
        if (srst) begin
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            alert_out_n <= 1'b1;
            critical_overtemp_out_n <= 1'b1;
            second_critical_out_n <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n <= ~(drive & ~timed_out);
            alert_out_n <= ~alert_drv;
            critical_overtemp_out_n <= ~(crit_l | crit_r);
            second_critical_out_n <= ~(pin6_crit2 & (crit2_l | crit2_r));
        end
    end
endmodule // tmr_regs

/* File: tb/tmr_regs_asserts.sv */
// concurrent checks on the pins of the register bank
module tmr_regs_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic alert_out_n,
    input wire logic second_critical_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic scl_q;
    logic sda_q;
    logic in_xfer;
    wire start_w = scl_in && scl_q && sda_q && !sda_in;
    wire stop_w = scl_in && scl_q && !sda_q && sda_in;
    always_ff @(posedge clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        if (srst) in_xfer <= 1'b0;
        else if (start_w) in_xfer <= 1'b1;
        else if (stop_w) in_xfer <= 1'b0;
    end
    sequence s_start; start_w; endsequence
    sequence s_stop; stop_w; endsequence
    sequence s_quiet; sda_oe_n [*8]; endsequence
    property p_slave_pull; !sda_out; endproperty
    property p_addressed; !sda_oe_n |-> in_xfer; endproperty
    property p_ack_low; $fell(sda_oe_n) |-> !scl_in && !$past(scl_in); endproperty
    property p_hold_high; scl_in && $past(scl_in) |-> $stable(sda_oe_n); endproperty
    property p_bit_stands; $fell(sda_oe_n) |=> !sda_oe_n [*8]; endproperty
    property p_start_quiet; s_start |=> s_quiet; endproperty
    property p_stop_quiet; s_stop |=> s_quiet; endproperty
    property p_pin6_excl; !(!alert_out_n && !second_critical_out_n); endproperty
    a_slave_pull: assert property (p_slave_pull) else $error("sda driven high");
    a_addressed: assert property (p_addressed) else $error("sda pulled outside");
    a_ack_low: assert property (p_ack_low) else $error("sda moved with scl high");
    a_hold_high: assert property (p_hold_high) else $error("sda changed in high");
    a_bit_stands: assert property (p_bit_stands) else $error("low bit too short");
    a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
    a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
    a_pin6_excl: assert property (p_pin6_excl) else $error("both pin6 modes low");
endmodule // tmr_regs_chk
bind tmr_regs tmr_regs_chk u_chk (.clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out_n(alert_out_n),
    .second_critical_out_n(second_critical_out_n));

/* File: tb/tmr_host.sv */
// bus master model driving the two-wire management bus
module tmr_host (
    input wire logic clk,
    input wire logic sda_pin,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] DEV = 7'h4C;
    int hp = 10;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic put_bit(input logic b, output logic seen);
        repeat (2) @(posedge clk);
        sda_drv <= b; // data moves only while the clock is low
        repeat (hp) @(posedge clk);
        scl <= 1'b1;
        repeat (hp) @(posedge clk);
        seen = sda_pin;
        scl <= 1'b0;
    endtask
    task automatic start_c();
        sda_drv <= 1'b0;
        repeat (hp) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        repeat (2) @(posedge clk);
        sda_drv <= 1'b0;
        repeat (hp) @(posedge clk);
        scl <= 1'b1;
        repeat (hp) @(posedge clk);
        sda_drv <= 1'b1;
        repeat (hp) @(posedge clk);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic nk;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
        put_bit(1'b1, nk);
        ack = !nk;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic two,
        output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        start_c();
        xfer({DEV, 1'b0}, r, a0);
        xfer(p, r, a1);
        a2 = 1'b1;
        if (two) xfer(d, r, a2);
        stop_c();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(output logic [7:0] q);
        logic a;
        start_c();
        xfer({DEV, 1'b1}, q, a);
        xfer(8'hFF, q, a);
        stop_c();
    endtask
endmodule // tmr_host

/* File: tb/thermal_monitor_register_map_test.sv */
// self-checking bench for the thermal monitor register bank
module thermal_monitor_register_map_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ID_PART = 8'h5A; // arbitrary value
    localparam logic [7:0] ID_MAKER = 8'hA5; // arbitrary value
    localparam logic [7:0] ID_REV = 8'h01; // arbitrary value
    logic clk = 1'b0;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic meas_valid = 1'b0;
    tmr_pkg::tmr_meas_t meas = '0;
    logic scl, sda_drv, sda_out, sda_oe_n, alert_n, crit_n, crit2_n, meas_run, ok;
    logic [7:0] q;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    logic [15:0] rtab [21] = '{16'h0000, 16'h0100, 16'h0308, 16'h0406, 16'h0555, 16'h0600,
        16'h0755, 16'h0800, 16'h1000, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h1955,
        16'h2055, 16'h210A, 16'h2201, {8'h3D, ID_PART}, {8'hFE, ID_MAKER},
        {8'hFF, ID_REV}, 16'h3000};
    logic [31:0] wtab [11] = '{32'h0B055050, 32'h0C060505, 32'h0D076060, 32'h13134040,
        32'h0E080303, 32'h14148080, 32'h1111FCFC, 32'h1212FFC0, 32'h00007700,
        32'h10107700, 32'h0F0FAB00};
    logic [7:0] fcode [4] = '{8'h01, 8'h03, 8'h07, 8'h0F};
    wire sda_pin = sda_drv & (sda_oe_n | sda_out); // pull-up on the wire
    always #10 clk = ~clk;
    initial begin
        #7;
        forever #15 mclk = ~mclk;
    end
    tmr_regs #(.TIMEOUT_CYC(200)) dut (.clk(clk), .srst(srst), .scl_in(scl),
        .sda_in(sda_pin), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out_n(alert_n),
        .critical_overtemp_out_n(crit_n), .second_critical_out_n(crit2_n),
        .meas_clk(mclk), .meas_valid(meas_valid), .meas_data(meas), .meas_run(meas_run));
    tmr_host host (.clk(clk), .sda_pin(sda_pin), .scl(scl), .sda_drv(sda_drv));
    task automatic stop_test();
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d, 1'b1, ok);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        host.wr(a, 8'h00, 1'b0, ok);
        chk("pointer ack", 8'h01, {7'h00, ok});
        host.rd(q);
        chk($sformatf("reg %h", a), exp, q);
    endtask
    task automatic send(input logic [7:0] loc, input logic [9:0] rem);
        @(posedge mclk);
        meas <= '{1'b0, rem, loc};
        meas_valid <= 1'b1;
        @(posedge mclk);
        meas_valid <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk); // link side still sees two reset edges after release
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        foreach (rtab[i]) rreg(rtab[i][15:8], rtab[i][7:0]);
        foreach (wtab[i]) begin
            wreg(wtab[i][31:24], wtab[i][15:8]);
            rreg(wtab[i][23:16], wtab[i][7:0]);
        end
        send(8'h19, 10'h0C8); // offset -3.25 takes 200 quarters to 187
        rreg(8'h01, 8'h2E);
        rreg(8'h10, 8'hC0);
        for (int n = 1; n <= 4; n++) begin
            wreg(8'h22, fcode[n-1]);
            send(8'h19, 10'h0C8);
            host.wr(8'h02, 8'h00, 1'b0, ok);
            host.rd(q);
            chk("alert cleared", 8'h01, {7'h00, alert_n});
            repeat (n - 1) send(8'h19, 10'h200);
            send(8'h19, 10'h0C8);
            repeat (n - 1) send(8'h19, 10'h200);
            chk("alert filtered", 8'h01, {7'h00, alert_n});
            send(8'h19, 10'h200);
            chk("alert raised", 8'h00, {7'h00, alert_n});
        end
        wreg(8'h09, 8'h48);
        repeat (20) @(posedge clk);
        chk("standby run", 8'h00, {7'h00, meas_run});
        send(8'h22, 10'h0C8);
        rreg(8'h00, 8'h19);
        wreg(8'h0F, 8'h00);
        repeat (20) @(posedge clk);
        chk("one shot run", 8'h01, {7'h00, meas_run});
        send(8'h22, 10'h0C8);
        rreg(8'h00, 8'h22);
        chk("back to standby", 8'h00, {7'h00, meas_run});
        host.start_c();
        host.xfer(8'h98, q, ok);
        host.xfer(8'h0B, q, ok);
        host.xfer(8'h44, q, ok);
        host.xfer(8'h33, q, ok);
        chk("third byte ack", 8'h00, {7'h00, ok});
        host.stop_c();
        rreg(8'h05, 8'h44);
        wreg(8'h22, 8'hC1);
        host.wr(8'h06, 8'h00, 1'b0, ok);
        host.start_c();
        host.xfer(8'h99, q, ok);
        repeat (150) @(posedge clk);
        chk("stalled bit", 8'h00, {7'h00, sda_oe_n});
        repeat (100) @(posedge clk);
        chk("timed out", 8'h01, {7'h00, sda_oe_n});
        host.stop_c();
        host.hp = 30; // slow master after the abort
        rreg(8'h22, 8'hC1);
        stop_test();
    end
endmodule // thermal_monitor_register_map_test
